/* common/sbfe_pkg.sv */
// constants and carriers for the serial boot flash erase sequencer
// Operation
// - host sends 5AH at 9600; device echoes 5AH, else stays silent and waits
// - valid baud byte echoed; bad one sends A1H, A3H, 62H thrice, halts
// - fifth byte F0H accepted at new rate and echoed as sixth byte
// - unknown command sends A1H, A3H, 63H three times each, then halts
// - 24-bit password count address follows, high byte first, no answer
// - 24-bit password compare address follows, high byte first, no answer
// - password string from byte thirteen on, device answers nothing
// - password mismatch stops all serial traffic and halts the device
// - reception error during addresses or password halts the device
// - erase-area byte: upper nibble start, lower nibble end of region
// - after area byte, checksum high then low byte; nothing on error
// - checksum returned only without reception or record format error
// - after both checksum bytes, wait for next command at new rate
// - new baud rate applied only after its echo has been sent
// - erased locations afterwards read FFH
// - under read protection only full-chip erase allowed, clears it; here readProt is only an input and nothing clears it
// - part is blank, password skipped, when FFFE0H..FFFFFH all FFH
package sbfe_pkg;
  // ****************************************
  // link bytes
  // ****************************************
  localparam logic [7:0] MATCH_BYTE = 8'h5a;
  localparam logic [7:0] ERR_LEAD0  = 8'ha1;
  localparam logic [7:0] ERR_LEAD1  = 8'ha3;
  localparam logic [7:0] ERR_BAUD   = 8'h62;
  localparam logic [7:0] ERR_CMD    = 8'h63;
  localparam logic [7:0] ERASED_VAL = 8'hff;
  localparam logic [7:0] BAUD_INIT  = 8'h28;
  // ****************************************
  // operation commands
  // ****************************************
  localparam logic [7:0] CMD_ERASE = 8'hf0;
  localparam logic [7:0] CMD_WRITE = 8'h30;
  localparam logic [7:0] CMD_RAML  = 8'h60;
  localparam logic [7:0] CMD_SUM   = 8'h90;
  localparam logic [7:0] CMD_ID    = 8'hc0;
  localparam logic [7:0] CMD_STAT  = 8'hc3;
  localparam logic [7:0] CMD_PROT  = 8'hfa;
  // ****************************************
  // layout and counts
  // ****************************************
  localparam logic [23:0] BLANK_LO   = 24'h0fffe0;
  localparam logic [5:0]  BLANK_CNT  = 6'h20;
  localparam logic [3:0]  ADDR_BYTES = 4'h6;
  localparam logic [3:0]  ERR_REPS   = 4'h3;
  localparam logic [3:0]  ERR_TOTAL  = 4'h9;
  localparam logic [7:0]  AREA_FULL  = 8'h0f;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] data;
    logic       err;
  } sbfe_rx_t;
  typedef struct packed {
    logic [3:0] startSel;
    logic [3:0] endSel;
  } sbfe_area_t;
endpackage : sbfe_pkg

/* core/sbfe_core.sv */
// serial boot flash erase command sequencer
`timescale 1ns/100ps
module sbfe_core #(
  parameter int          ADDR_W = 24,
  parameter logic [7:0]  BAUD_A = 8'h28,
  parameter logic [7:0]  BAUD_B = 8'h18,
  parameter logic [7:0]  BAUD_C = 8'h07,
  parameter logic [7:0]  BAUD_D = 8'h0a,
  parameter logic [7:0]  BAUD_E = 8'h05
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // received bytes from the uart
  input  wire logic              rxValid,
  input  wire sbfe_pkg::sbfe_rx_t rxByte,
  // bytes to the uart
  output logic                   txValid,
  output logic [7:0]             txData,
  input  wire logic              txReady,
  // baud selection for the uart
  output logic [7:0]             baudSel,
  // flash read port
  output logic                   rdReq,
  output logic [ADDR_W-1:0]      rdAddr,
  input  wire logic              rdAck,
  input  wire logic [7:0]        rdData,
  // erase engine
  output logic                   eraseReq,
  output sbfe_pkg::sbfe_area_t   eraseArea,
  input  wire logic              eraseDone,
  input  wire logic              eraseFail,
  input  wire logic [15:0]       eraseSum,
  input  wire logic              readProt,
  // status
  output logic                   halted
);

  if (ADDR_W < 20 || ADDR_W > 24) begin : g_chk
    $error("sbfe_core: ADDR_W must lie in 20..24");
  end

  // ****************************************
  // reset release
  // ****************************************
  logic rstMeta_r;
  logic rstSync_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  typedef enum logic [4:0] {
    S_MATCH, S_BAUD, S_BAPPLY, S_CMD, S_ADDR, S_BLKRD, S_BLKWT,
    S_CNTRD, S_CNTWT, S_PWDRX, S_PWDWT, S_AREA, S_ERASE,
    S_SUMLO, S_SEND, S_ERR, S_HALT
  } sbfe_state_t;

  sbfe_state_t state_r, state_nxt, ret_r, ret_nxt;
  logic              txValid_r, txValid_nxt;
  logic [7:0]        txData_r, txData_nxt;
  logic [7:0]        baud_r, baud_nxt;
  logic [47:0]       addrs_r, addrs_nxt;
  logic [7:0]        idx_r, idx_nxt;
  logic [7:0]        pwdLen_r, pwdLen_nxt;
  logic [7:0]        pwdByte_r, pwdByte_nxt;
  logic              rdReq_r, rdReq_nxt;
  logic [23:0]       rdAddr_r, rdAddr_nxt;
  logic              blank_r, blank_nxt;
  logic [3:0]        errCnt_r, errCnt_nxt;
  logic [7:0]        errCode_r, errCode_nxt;
  logic              erReq_r, erReq_nxt;
  sbfe_pkg::sbfe_area_t area_r, area_nxt;
  logic [7:0]        sumLo_r, sumLo_nxt;
  logic              halted_r, halted_nxt;

  // ****************************************
  // decoding
  // ****************************************
  wire        rxOk     = rxValid && !rxByte.err;
  wire        rxBad    = rxValid && rxByte.err;
  wire [7:0]  rxd      = rxByte.data;
  wire        txDone   = txValid_r && txReady;
  wire        baudOk   = rxd == BAUD_A || rxd == BAUD_B ||
                         rxd == BAUD_C || rxd == BAUD_D || rxd == BAUD_E;
  wire        cmdKnown = rxd == sbfe_pkg::CMD_ERASE ||
                         rxd == sbfe_pkg::CMD_WRITE ||
                         rxd == sbfe_pkg::CMD_RAML ||
                         rxd == sbfe_pkg::CMD_SUM ||
                         rxd == sbfe_pkg::CMD_ID ||
                         rxd == sbfe_pkg::CMD_STAT ||
                         rxd == sbfe_pkg::CMD_PROT;
  wire [23:0] cntAddr  = addrs_r[47:24];
  wire [23:0] cmpAddr  = addrs_r[23:0];
  wire        lastBlk  = idx_r == {2'h0, sbfe_pkg::BLANK_CNT} - 8'h01;
  wire        lastPwd  = idx_r + 8'h01 == pwdLen_r;
  wire        pwdMiss  = rdData != pwdByte_r;
  wire [7:0]  errByte  = (errCnt_r < sbfe_pkg::ERR_REPS) ?
                         sbfe_pkg::ERR_LEAD0 :
                         (errCnt_r < 2 * sbfe_pkg::ERR_REPS) ?
                         sbfe_pkg::ERR_LEAD1 : errCode_r;
  wire        areaFull = rxd == sbfe_pkg::AREA_FULL;

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    state_nxt   = state_r;
    ret_nxt     = ret_r;
    txValid_nxt = txValid_r;
    txData_nxt  = txData_r;
    baud_nxt    = baud_r;
    addrs_nxt   = addrs_r;
    idx_nxt     = idx_r;
    pwdLen_nxt  = pwdLen_r;
    pwdByte_nxt = pwdByte_r;
    rdReq_nxt   = 1'b0;
    rdAddr_nxt  = rdAddr_r;
    blank_nxt   = blank_r;
    errCnt_nxt  = errCnt_r;
    errCode_nxt = errCode_r;
    erReq_nxt   = erReq_r;
    area_nxt    = sbfe_pkg::sbfe_area_t'(rxd);
    sumLo_nxt   = sumLo_r;
    halted_nxt  = halted_r;
    unique case (state_r)
      S_MATCH: if (rxOk && rxd == sbfe_pkg::MATCH_BYTE) begin
        txValid_nxt = 1'b1;
        txData_nxt  = rxd;
        ret_nxt     = S_BAUD;
        state_nxt   = S_SEND;
      end
      S_BAUD: if (rxValid) begin
        if (rxOk && baudOk) begin
          txValid_nxt = 1'b1;
          txData_nxt  = rxd;
          ret_nxt     = S_BAPPLY;
          state_nxt   = S_SEND;
        end else begin
          errCode_nxt = sbfe_pkg::ERR_BAUD;
          state_nxt   = S_ERR;
        end
      end
      S_BAPPLY: begin
        baud_nxt  = txData_r;
        state_nxt = S_CMD;
      end
      S_CMD: if (rxValid) begin
        if (rxBad || !cmdKnown) begin
          errCode_nxt = sbfe_pkg::ERR_CMD;
          state_nxt   = S_ERR;
        end else begin
          txValid_nxt = 1'b1;
          txData_nxt  = rxd;
          idx_nxt     = 8'h00;
          ret_nxt     = (rxd == sbfe_pkg::CMD_ERASE) ? S_ADDR : S_CMD;
          state_nxt   = S_SEND;
        end
      end
      S_ADDR: if (rxBad) begin
        state_nxt = S_HALT;
      end else if (rxOk) begin
        addrs_nxt = {addrs_r[39:0], rxd};
        idx_nxt   = idx_r + 8'h01;
        if (idx_r == {4'h0, sbfe_pkg::ADDR_BYTES} - 8'h01) begin
          idx_nxt    = 8'h00;
          blank_nxt  = 1'b1;
          rdAddr_nxt = sbfe_pkg::BLANK_LO;
          state_nxt  = S_BLKRD;
        end
      end
      S_BLKRD: begin
        rdReq_nxt = 1'b1;
        state_nxt = S_BLKWT;
      end
      S_BLKWT: if (rdAck) begin
        blank_nxt = blank_r && rdData == sbfe_pkg::ERASED_VAL;
        idx_nxt   = idx_r + 8'h01;
        if (lastBlk) begin
          rdAddr_nxt = cntAddr;
          state_nxt  = (blank_nxt) ? S_AREA : S_CNTRD;
        end else begin
          rdAddr_nxt = rdAddr_r + 24'h000001;
          state_nxt  = S_BLKRD;
        end
      end
      S_CNTRD: begin
        rdReq_nxt = 1'b1;
        state_nxt = S_CNTWT;
      end
      S_CNTWT: if (rdAck) begin
        pwdLen_nxt = rdData;
        idx_nxt    = 8'h00;
        rdAddr_nxt = cmpAddr;
        state_nxt  = (rdData == 8'h00) ? S_HALT : S_PWDRX;
      end
      S_PWDRX: if (rxBad) begin
        state_nxt = S_HALT;
      end else if (rxOk) begin
        pwdByte_nxt = rxd;
        rdReq_nxt   = 1'b1;
        state_nxt   = S_PWDWT;
      end
      S_PWDWT: if (rdAck) begin
        idx_nxt    = idx_r + 8'h01;
        rdAddr_nxt = rdAddr_r + 24'h000001;
        if (pwdMiss) begin
          state_nxt = S_HALT;
        end else begin
          state_nxt = (lastPwd) ? S_AREA : S_PWDRX;
        end
      end
      S_AREA: if (rxBad) begin
        state_nxt = S_HALT;
      end else if (rxOk) begin
        if (readProt && !areaFull) begin
          state_nxt = S_HALT;
        end else begin
          erReq_nxt = 1'b1;
          state_nxt = S_ERASE;
        end
      end
      S_ERASE: if (eraseDone) begin
        erReq_nxt = 1'b0;
        if (eraseFail) begin
          state_nxt = S_HALT;
        end else begin
          txValid_nxt = 1'b1;
          txData_nxt  = eraseSum[15:8];
          sumLo_nxt   = eraseSum[7:0];
          ret_nxt     = S_SUMLO;
          state_nxt   = S_SEND;
        end
      end
      S_SUMLO: begin
        txValid_nxt = 1'b1;
        txData_nxt  = sumLo_r;
        ret_nxt     = S_CMD;
        state_nxt   = S_SEND;
      end
      S_SEND: if (txDone) begin
        txValid_nxt = 1'b0;
        state_nxt   = ret_r;
      end
      S_ERR: if (!txValid_r) begin
        txValid_nxt = 1'b1;
        txData_nxt  = errByte;
      end else if (txReady) begin
        txValid_nxt = 1'b0;
        errCnt_nxt  = errCnt_r + 4'h1;
        if (errCnt_r == sbfe_pkg::ERR_TOTAL - 4'h1) begin
          state_nxt = S_HALT;
        end
      end
      S_HALT: begin
        txValid_nxt = 1'b0;
        erReq_nxt   = 1'b0;
        halted_nxt  = 1'b1;
      end
      default: state_nxt = S_HALT;
    endcase
  end

  // ****************************************
  // state registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      state_r   <= S_MATCH;
      ret_r     <= S_MATCH;
      txValid_r <= 1'b0;
      txData_r  <= 8'h00;
      baud_r    <= sbfe_pkg::BAUD_INIT;
      addrs_r   <= 48'h000000000000;
      idx_r     <= 8'h00;
      pwdLen_r  <= 8'h00;
      pwdByte_r <= 8'h00;
      rdReq_r   <= 1'b0;
      rdAddr_r  <= 24'h000000;
      blank_r   <= 1'b0;
      errCnt_r  <= 4'h0;
      errCode_r <= 8'h00;
      erReq_r   <= 1'b0;
      area_r    <= 8'h00;
      sumLo_r   <= 8'h00;
      halted_r  <= 1'b0;
    end else if (ce) begin
      state_r   <= state_nxt;
      ret_r     <= ret_nxt;
      txValid_r <= txValid_nxt;
      txData_r  <= txData_nxt;
      baud_r    <= baud_nxt;
      addrs_r   <= addrs_nxt;
      idx_r     <= idx_nxt;
      pwdLen_r  <= pwdLen_nxt;
      pwdByte_r <= pwdByte_nxt;
      rdReq_r   <= rdReq_nxt;
      rdAddr_r  <= rdAddr_nxt;
      blank_r   <= blank_nxt;
      errCnt_r  <= errCnt_nxt;
      errCode_r <= errCode_nxt;
      erReq_r   <= erReq_nxt;
      if (state_r == S_AREA && rxOk) begin
        area_r <= area_nxt;
      end
      sumLo_r   <= sumLo_nxt;
      halted_r  <= halted_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign txValid   = txValid_r;
  assign txData    = txData_r;
  assign baudSel   = baud_r;
  assign rdReq     = rdReq_r;
  assign rdAddr    = rdAddr_r[ADDR_W-1:0];
  assign eraseReq  = erReq_r;
  assign eraseArea = area_r;
  assign halted    = halted_r;

endmodule : sbfe_core

/* test/sbfe_core_sva.sv */
// port assertions for the erase sequencer
`timescale 1ns/100ps
module sbfe_core_sva #(
  parameter int ADDR_W = 24
) (
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 nrst,
  input wire logic                 ce,
  // link side
  input wire logic                 rxValid,
  input wire sbfe_pkg::sbfe_rx_t   rxByte,
  input wire logic                 txValid,
  input wire logic [7:0]           txData,
  input wire logic                 txReady,
  input wire logic [7:0]           baudSel,
  // flash and erase side
  input wire logic                 rdReq,
  input wire logic [ADDR_W-1:0]    rdAddr,
  input wire logic                 rdAck,
  input wire logic [7:0]           rdData,
  input wire logic                 eraseReq,
  input wire sbfe_pkg::sbfe_area_t eraseArea,
  input wire logic                 eraseDone,
  input wire logic                 eraseFail,
  input wire logic [15:0]          eraseSum,
  input wire logic                 readProt,
  input wire logic                 halted
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_tx_offer_held: assert property (
    txValid && !txReady |=> txValid && $stable(txData))
    else $error("tx offer dropped");
  a_halt_sticky: assert property (
    halted |=> halted) else $error("halt left");
  a_halt_silent: assert property (
    halted |-> !txValid && !eraseReq && !rdReq)
    else $error("activity while halted");
  a_erase_held: assert property (
    eraseReq && !eraseDone |=> eraseReq && $stable(eraseArea))
    else $error("erase request dropped");
  a_sum_high_first: assert property (
    eraseReq && eraseDone && !eraseFail |=>
      txValid && txData == $past(eraseSum[15:8]))
    else $error("checksum high byte missing");
  a_fail_halts: assert property (
    eraseReq && eraseDone && eraseFail |-> ##[1:2] halted)
    else $error("erase fault not halted");
  a_no_tx_erasing: assert property (
    eraseReq |-> !txValid) else $error("tx during erase");
  a_baud_after_echo: assert property (
    $changed(baudSel) |-> !txValid && ($past(txValid && txReady, 2)
      || $past(txValid && txReady, 3)))
    else $error("baud changed before echo sent");
  a_prot_full_only: assert property (
    eraseReq |-> !readProt || eraseArea == sbfe_pkg::AREA_FULL)
    else $error("sector erase under protection");
  a_ce_freeze: assert property (
    !ce |=> $stable(txValid) && $stable(baudSel) && $stable(halted))
    else $error("state moved while clock enable low");
endmodule : sbfe_core_sva

bind sbfe_core sbfe_core_sva #(.ADDR_W(ADDR_W)) i_sbfe_core_sva (
  .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .rxValid(rxValid),
  .rxByte(rxByte), .txValid(txValid), .txData(txData),
  .txReady(txReady), .baudSel(baudSel), .rdReq(rdReq),
  .rdAddr(rdAddr), .rdAck(rdAck), .rdData(rdData),
  .eraseReq(eraseReq), .eraseArea(eraseArea), .eraseDone(eraseDone),
  .eraseFail(eraseFail), .eraseSum(eraseSum), .readProt(readProt),
  .halted(halted));

/* test/sbfe_flash_model.sv */
// flash, erase engine and uart transmit stand-in
`timescale 1ns/100ps
module sbfe_flash_model (
  // clock and controls
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        blank,
  input  wire logic        slow,
  // uart transmit side
  input  wire logic        txValid,
  output logic             txReady = 1'b0,
  // flash read port
  input  wire logic        rdReq,
  input  wire logic [23:0] rdAddr,
  output logic             rdAck = 1'b0,
  output logic [7:0]       rdData = 8'h00,
  // erase engine
  input  wire logic        eraseReq,
  output logic             eraseDone = 1'b0,
  output logic [15:0]      eraseSum = 16'h0000
);
  logic [23:0] adr = 24'h000000;
  logic        pend = 1'b0;
  logic        erased = 1'b0;
  logic [2:0]  wt = 3'h0;
  logic [2:0]  ec = 3'h0;
  logic [7:0]  val;
  assign val = (adr >= 24'h0fffe0) ? ((blank || erased) ? 8'hff
             : adr[7:0]) : (adr == 24'h000100) ? 8'h02
             : adr[7:0] + 8'h40;
  always @(posedge sys_clk) begin
    pend <= rdReq;
    rdAck <= pend;
    if (rdReq) adr <= rdAddr;
    rdData <= pend ? val : ~rdData;
    wt <= (txValid && !txReady) ? wt + 3'h1 : 3'h0;
    txReady <= txValid && !txReady && (!slow || wt >= 3'h3);
    ec <= (eraseReq && !eraseDone) ? ec + 3'h1 : 3'h0;
    eraseDone <= (ec == 3'h5);
    eraseSum <= (ec == 3'h5) ? 16'hc3a5 : ~eraseSum;
    if (!nrst) erased <= 1'b0;
    else if (ec == 3'h5) erased <= 1'b1;
  end
endmodule : sbfe_flash_model

/* test/tb_sbfe_core.sv */
// self-checking bench for the erase sequencer
`timescale 1ns/100ps
module tb_sbfe_core;
  logic sys_clk = 0, nrst = 0, ce = 1, rxValid = 0, eraseFail = 0;
  logic readProt = 0, blank = 1, slow = 0;
  logic txValid, txReady, rdReq, rdAck, eraseReq, eraseDone, halted;
  logic [7:0] txData, baudSel, rdData;
  logic [23:0] rdAddr;
  logic [15:0] eraseSum;
  sbfe_pkg::sbfe_rx_t rxByte = '0;
  sbfe_pkg::sbfe_area_t eraseArea;
  logic [7:0] txq[$], ex[$];
  localparam logic [7:0] ADR[6] = '{8'h00, 8'h01, 8'h00,
                                   8'h00, 8'h02, 8'h00};
  int n_fail = 0, checks_done = 0, cyc = 0, quiet = 0;
  always #5 sys_clk = ~sys_clk;
  sbfe_core i_sbfe_core (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
    .rxValid(rxValid), .rxByte(rxByte), .txValid(txValid),
    .txData(txData), .txReady(txReady), .baudSel(baudSel),
    .rdReq(rdReq), .rdAddr(rdAddr), .rdAck(rdAck), .rdData(rdData),
    .eraseReq(eraseReq), .eraseArea(eraseArea),
    .eraseDone(eraseDone), .eraseFail(eraseFail),
    .eraseSum(eraseSum), .readProt(readProt), .halted(halted));
  sbfe_flash_model i_sbfe_flash_model (.sys_clk(sys_clk), .nrst(nrst),
    .blank(blank), .slow(slow), .txValid(txValid), .txReady(txReady),
    .rdReq(rdReq), .rdAddr(rdAddr), .rdAck(rdAck), .rdData(rdData),
    .eraseReq(eraseReq), .eraseDone(eraseDone), .eraseSum(eraseSum));
  always @(posedge sys_clk) begin
    if (txValid && txReady) txq.push_back(txData);
    quiet <= (txValid || rdReq || rdAck || eraseReq || rxValid)
           ? 0 : quiet + 1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      $display("unexpected at %0t: timeout", $time);
      test_done();
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_tx();
    chk(8'(txq.size()), 8'(ex.size()));
    foreach (ex[i]) chk((i < txq.size()) ? txq[i] : 8'hxx, ex[i]);
    txq = {};
    ex = {};
  endtask : chk_tx
  task automatic send(input logic [7:0] b, input logic e = 1'b0);
    int i;
    @(posedge sys_clk);
    rxValid <= 1'b1;
    rxByte <= {b, e};
    @(posedge sys_clk);
    rxValid <= 1'b0;
    @(posedge sys_clk);
    i = 0;
    while (quiet < 6 && i < 500) begin
      @(posedge sys_clk);
      i++;
    end
  endtask : send
  task automatic rst(input logic bl);
    @(posedge sys_clk);
    nrst <= 1'b0;
    blank <= bl;
    readProt <= 1'b0;
    eraseFail <= 1'b0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    txq = {};
  endtask : rst
  task automatic sync();
    send(sbfe_pkg::MATCH_BYTE);
    send(8'h18);
    txq = {};
  endtask : sync
  task automatic burst(input logic [7:0] code);
    for (int i = 0; i < 9; i++)
      ex.push_back(i < 3 ? 8'ha1 : i < 6 ? 8'ha3 : code);
  endtask : burst
  task automatic erase_seq(input logic [7:0] pw, input logic [7:0] area,
                           input int errAt);
    send(sbfe_pkg::CMD_ERASE);
    for (int i = 0; i < 6; i++) send(ADR[i], i == errAt);
    if (!blank) begin
      send(8'h40);
      send(pw);
    end
    send(area);
  endtask : erase_seq
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_sync();
    rst(1'b1);
    slow <= 1'b1;
    send(8'h00);
    send(sbfe_pkg::MATCH_BYTE);
    send(8'h18);
    ex = {8'h5a, 8'h18};
    chk_tx();
    chk(baudSel, 8'h18);
    slow <= 1'b0;
    ce <= 1'b0;
    send(sbfe_pkg::CMD_SUM);
    ce <= 1'b1;
    chk_tx();
  endtask : t_sync
  task automatic t_bad_baud();
    rst(1'b1);
    send(sbfe_pkg::MATCH_BYTE);
    send(8'h99);
    ex = {8'h5a};
    burst(8'h62);
    chk_tx();
    chk(halted, 8'h01);
  endtask : t_bad_baud
  task automatic t_bad_cmd();
    rst(1'b1);
    sync();
    send(8'h55);
    send(sbfe_pkg::MATCH_BYTE);
    burst(8'h63);
    chk_tx();
    chk(halted, 8'h01);
  endtask : t_bad_cmd
  task automatic t_erase(input logic bl, input logic [7:0] area);
    rst(bl);
    readProt <= (area == sbfe_pkg::AREA_FULL);
    sync();
    erase_seq(8'h41, area, 9);
    chk(eraseArea, area);
    ex = {8'hf0, 8'hc3, 8'ha5};
    chk_tx();
    send(sbfe_pkg::CMD_SUM);
    ex = {8'h90};
    chk_tx();
    chk(halted, 8'h00);
  endtask : t_erase
  task automatic t_halt(input logic [7:0] pw, input logic [7:0] area,
                        input int errAt);
    erase_seq(pw, area, errAt);
    ex = {8'hf0};
    chk_tx();
    chk(halted, 8'h01);
  endtask : t_halt
  task automatic t_pwd_bad();
    rst(1'b0);
    sync();
    t_halt(8'h99, 8'h12, 9);
  endtask : t_pwd_bad
  task automatic t_rx_err();
    rst(1'b1);
    sync();
    t_halt(8'h41, 8'h12, 1);
  endtask : t_rx_err
  task automatic t_fail();
    rst(1'b1);
    eraseFail <= 1'b1;
    sync();
    t_halt(8'h41, 8'h0f, 9);
  endtask : t_fail
  task automatic t_prot();
    rst(1'b1);
    readProt <= 1'b1;
    sync();
    t_halt(8'h41, 8'h12, 9);
  endtask : t_prot
  initial begin
    t_sync();
    t_bad_baud();
    t_bad_cmd();
    t_erase(1'b1, 8'h0f);
    t_erase(1'b0, 8'h12);
    t_pwd_bad();
    t_rx_err();
    t_fail();
    t_prot();
    test_done();
  end
endmodule : tb_sbfe_core
